// File: include/pmi_pkg.sv
package pmi_pkg;

	// interface mode, taken from the straps after reset
	typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_SERIAL} pmi_mode_type;

	// system clock
	localparam int CLK_PERIOD_NS = 50;

	// link clock periods and heartbeat length as printed, in ns
	localparam int MII100_CLK_NS = 40;
	localparam int MII10_CLK_NS = 400;
	localparam int SERIAL_CLK_NS = 100;
	localparam int RMII_REF_NS = 20;
	localparam int HEARTBEAT_NS = 1000;

	// link clock half periods, the full rmii reference period and the heartbeat length in system cycles, rounded down, never below one cycle
	localparam int MII100_HALF = (MII100_CLK_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
		MII100_CLK_NS / 2 / CLK_PERIOD_NS;
	localparam int MII10_HALF = (MII10_CLK_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
		MII10_CLK_NS / 2 / CLK_PERIOD_NS;
	localparam int SERIAL_HALF = (SERIAL_CLK_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
		SERIAL_CLK_NS / 2 / CLK_PERIOD_NS;
	localparam int RMII_HALF = (RMII_REF_NS / CLK_PERIOD_NS) < 1 ? 1 :
		RMII_REF_NS / CLK_PERIOD_NS;
	localparam int HEARTBEAT_CYC = (HEARTBEAT_NS / CLK_PERIOD_NS) < 1 ? 1 :
		HEARTBEAT_NS / CLK_PERIOD_NS;

	// divider width
	localparam int DIV_W = 8;

	// register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

	// control fields
	localparam int CTRL_SPEED100_BIT = 0;
	localparam int CTRL_FULLDUP_BIT = 1;
	localparam int CTRL_HBEAT_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h5;

	// status fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_CRS_BIT = 2;
	localparam int STAT_COL_BIT = 3;
	localparam int STAT_TXACT_BIT = 4;
	localparam int STAT_LOCKED_BIT = 5;

	// pattern forced on receive data during a receive error
	localparam logic [3:0] CORRUPT_NIBBLE = 4'he;

endpackage

// File: tb/pmi_mac_data_if_tb.sv
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module pmi_mac_data_if_tb import pmi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic rst = 1;
	logic [3:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [3:0] avs_byteenable = 0;
	logic [31:0] avs_readdata, rdata, d;
	logic avs_waitrequest, tx_clk, rx_clk, rx_dv, rx_er, crs, col, line_tx_valid;
	logic strap_rmii = 0;
	logic strap_serial = 0;
	logic send = 0;
	logic tx_en;
	logic [3:0] txd, rxd, line_tx_data, exp;
	logic line_rx_carrier = 0;
	logic line_rx_valid = 0;
	logic [3:0] line_rx_data = 0;
	logic line_rx_symbol_err = 0;
	int failures = 0;
	int check_count = 0;
	int seed = 62250;
	int ctrl, nt, nr, n;

	pmi_mac_data_if u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .strap_rmii(strap_rmii),
		.strap_serial(strap_serial), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd),
		.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs), .col(col),
		.line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
		.line_rx_carrier(line_rx_carrier), .line_rx_valid(line_rx_valid),
		.line_rx_data(line_rx_data), .line_rx_symbol_err(line_rx_symbol_err));

	pmi_mac_model u_mac (.clk(clk), .rst(rst), .send(send), .rmii(strap_rmii),
		.serial(strap_serial), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd));

	// 20 MHz system clock
	initial forever #25 clk = ~clk;

	// one avalon transfer; waits for waitrequest low, the watchdog bounds a hang
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// straps are held steady across the release so the first edge latches them
	task automatic do_reset(input int m);
		@(posedge clk);
		strap_rmii <= (m == 1);
		strap_serial <= (m == 2);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		ctrl = CTRL_RESET;
	endtask

	// rising edges of both link clocks over 40 system cycles
	task automatic rises(output int ct, output int cr);
		logic pt, pr;
		ct = 0;
		cr = 0;
		pt = tx_clk;
		pr = rx_clk;
		repeat (40) begin
			@(negedge clk);
			ct += (tx_clk && !pt);
			cr += (rx_clk && !pr);
			pt = tx_clk;
			pr = rx_clk;
		end
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// every nibble on the line must be the next one the mac launched
	always @(negedge clk) begin
		if (line_tx_valid === 1'b1) begin
			exp = u_mac.sent.size() ? u_mac.sent.pop_front() : 4'hx;
			`CHK("line_tx", exp, line_tx_data)
		end
	end

	initial begin
		#2000000;
		failures++;
		test_done;
	end

	initial begin
		// each mode's strap setting, never both straps high, ending in mii
		for (int m = 2; m >= 0; m--) begin
			do_reset(m);
			bus(0, REG_STATUS, 0, 4'hf);
			`CHK("mode", m, rdata[1:0])
			`CHK("locked", 1, rdata[STAT_LOCKED_BIT])
			rises(nt, nr);
			`CHK("tx_clk", (m == 1) ? 0 : 20, nt)
			`CHK("rx_clk", (m == 1) ? 0 : 20, nr)
			// send while a bad symbol arrives: framing, error marking and collision per mode
			@(posedge clk);
			send <= 1'b1;
			line_rx_carrier <= 1'b1;
			line_rx_valid <= 1'b1;
			line_rx_symbol_err <= 1'b1;
			line_rx_data <= 4'h1;
			repeat (8) @(negedge clk);
			`CHK("m crs", 1, crs)
			`CHK("m rx_dv", (m != 2), rx_dv)
			`CHK("m rx_er", (m != 2), rx_er)
			`CHK("m rxd", ((m == 0) ? 7 : ((m == 1) ? 1 : 0)), rxd[3:1])
			if (m != 1)
				`CHK("m rxd0", (m == 2), rxd[0])
			`CHK("m col", (m != 1), col)
			`CHK("mac col", 1, ((m == 1) ? (crs & tx_en) : col))
			@(posedge clk);
			send <= 1'b0;
			line_rx_carrier <= 1'b0;
			line_rx_valid <= 1'b0;
			line_rx_symbol_err <= 1'b0;
			repeat (8) @(negedge clk);
			`CHK("m crs idle", 0, crs)
			`CHK("m tx left", 0, u_mac.sent.size())
		end
		bus(0, REG_CTRL, 0, 4'hf);
		`CHK("ctrl", ctrl, rdata)
		bus(1, 4'h8, 32'hffffffff, 4'hf);
		bus(0, 4'h8, 0, 4'hf);
		`CHK("unmapped", 0, rdata)
		bus(1, REG_CTRL, 32'h2, 4'he);
		bus(0, REG_CTRL, 0, 4'hf);
		`CHK("ctrl be", ctrl, rdata)
		d = $random(seed);
		bus(1, REG_CTRL, d, 4'hf);
		ctrl = d & 7;
		bus(0, REG_CTRL, 0, 4'hf);
		`CHK("ctrl rand", ctrl, rdata)
		// 100 Mb half duplex transmit, then carrier makes a collision
		bus(1, REG_CTRL, 32'h1, 4'h1);
		send <= 1'b1;
		repeat (30) @(posedge clk);
		line_rx_carrier <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK("col", 1, col)
		bus(1, REG_CTRL, 32'h3, 4'h1);
		repeat (6) @(negedge clk);
		`CHK("col fd", 0, col)
		@(posedge clk);
		send <= 1'b0;
		// receive a held nibble, then an error inside it
		d = $random(seed);
		line_rx_data <= d[3:0];
		line_rx_valid <= 1'b1;
		repeat (8) @(negedge clk);
		`CHK("rx_dv", 1, rx_dv)
		`CHK("crs", 1, crs)
		`CHK("rxd", d[3:0], rxd)
		@(posedge clk);
		line_rx_symbol_err <= 1'b1;
		repeat (8) @(negedge clk);
		`CHK("rx_er", 1, rx_er)
		`CHK("rxd err", CORRUPT_NIBBLE, rxd)
		@(posedge clk);
		line_rx_symbol_err <= 1'b0;
		line_rx_valid <= 1'b0;
		line_rx_carrier <= 1'b0;
		line_rx_data <= ~d[3:0];
		repeat (8) @(negedge clk);
		`CHK("crs idle", 0, crs)
		`CHK("rx_dv idle", 0, rx_dv)
		// 10 Mb half duplex with heartbeat after the frame
		bus(1, REG_CTRL, 32'h4, 4'h1);
		rises(nt, nr);
		`CHK("tx_clk 10", 5, nt)
		`CHK("rx_clk 10", 5, nr)
		@(posedge clk);
		send <= 1'b1;
		repeat (40) @(posedge clk);
		send <= 1'b0;
		n = 0;
		while (col !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
		`CHK("heartbeat", 1, col)
		repeat (30) @(negedge clk);
		`CHK("heartbeat end", 0, col)
		`CHK("tx left", 0, u_mac.sent.size())
		test_done;
	end
endmodule

// File: tb/pmi_mac_model.sv
// mac partner: one nibble per transmit clock period, or two dibits per nibble in rmii
module pmi_mac_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control
	input wire logic send,
	input wire logic rmii,
	input wire logic serial,
	// mac side
	input wire logic tx_clk,
	output logic tx_en,
	output logic [3:0] txd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] sent[$];
	logic [3:0] nib;
	logic tx_clk_q;
	logic half;
	int seed = 62250;

	// launch once per rising link edge so data is steady at the next sampling rise
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_en <= 1'b0;
			txd <= 4'h0;
			tx_clk_q <= 1'b0;
			half <= 1'b0;
			sent.delete();
		end else if (rmii) begin
			// rmii: a dibit every reference tick, tx_en held across both halves
			if (half) begin
				txd <= {2'h0, nib[3:2]};
				half <= 1'b0;
			end else begin
				nib = 4'($random(seed));
				tx_en <= send;
				txd <= {2'h0, nib[1:0]};
				half <= send;
				if (send)
					sent.push_back(nib);
			end
		end else begin
			tx_clk_q <= tx_clk;
			if (tx_clk && !tx_clk_q) begin
				nib = 4'($random(seed));
				tx_en <= send;
				txd <= nib; // idle data keeps changing, never a kind value
				if (send)
					sent.push_back(serial ? {3'h0, nib[0]} : nib);
			end
		end
	end
endmodule

// File: verilog/pmi_mac_data_if.sv
module pmi_mac_data_if import pmi_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// mode straps
	input wire logic strap_rmii,
	input wire logic strap_serial,
	// mac side
	output logic tx_clk,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	output logic rx_clk,
	output logic rx_dv,
	output logic rx_er,
	output logic [3:0] rxd,
	output logic crs,
	output logic col,
	// line side
	output logic line_tx_valid,
	output logic [3:0] line_tx_data,
	input wire logic line_rx_carrier,
	input wire logic line_rx_valid,
	input wire logic [3:0] line_rx_data,
	input wire logic line_rx_symbol_err
);

	pmi_mode_type mode;
	logic strap_done;
	logic [2:0] ctrl;
	logic bus_ack;
	logic lclk;
	logic tick;
	logic tx_en_q;
	logic tx_en_d;
	logic tx_phase;
	logic [1:0] tx_lo;
	logic rx_phase;
	logic [1:0] rx_hi;
	logic hb_active;
	logic [DIV_W-1:0] half_sel;

	// mode and control decode
	wire is_rmii = (mode == MODE_RMII);
	wire is_serial = (mode == MODE_SERIAL);
	wire is_mii = (mode == MODE_MII);
	wire speed100 = ctrl[CTRL_SPEED100_BIT];
	wire full_duplex = ctrl[CTRL_FULLDUP_BIT];
	wire hb_enable = ctrl[CTRL_HBEAT_BIT];
	wire ten_meg = is_serial | ~speed100;
	wire pmi_mode_type next_mode = strap_serial ? MODE_SERIAL :
		(strap_rmii ? MODE_RMII : MODE_MII);

	// mode locked at the first edge after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= MODE_MII;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			mode <= next_mode;
			strap_done <= 1'b1;
		end
	end

	// bus slave: one wait state; read data is formed during it
	wire bus_req = avs_read | avs_write;
	wire bus_take = bus_req & bus_ack;
	wire sel_ctrl = (avs_address == REG_CTRL);
	wire sel_status = (avs_address == REG_STATUS);
	wire [31:0] status_word = {26'h0, strap_done, tx_en_q, col, crs, mode};
	wire [31:0] next_readdata = sel_ctrl ? {29'h0, ctrl} :
		(sel_status ? status_word : 32'h0);
	assign avs_waitrequest = bus_req & ~bus_ack;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
			if (avs_read && !bus_ack) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	// control register; only byte lane 0 carries bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
		end else if (bus_take && avs_write && sel_ctrl && avs_byteenable[0]) begin
			ctrl <= avs_writedata[2:0];
		end
	end

	// link clock ratio; the fast rates are the nearest the system clock can reach
	assign half_sel = is_rmii ? DIV_W'(RMII_HALF) :
		is_serial ? DIV_W'(SERIAL_HALF) :
		speed100 ? DIV_W'(MII100_HALF) : DIV_W'(MII10_HALF);

	pmi_tick_div #(
		.WIDTH(DIV_W)
	) u_div (
		.clk(clk),
		.rst(rst),
		.half_count(half_sel),
		.tick(tick)
	);

	// link clock toggles on each tick; both pins stay low in rmii
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lclk <= 1'b0;
		end else if (tick) begin
			lclk <= ~lclk;
		end
	end

	assign tx_clk = lclk & ~is_rmii;
	assign rx_clk = lclk & ~is_rmii;

	// sample on the rising link edge, drive on the falling one; rmii every tick
	wire tx_sample = is_rmii ? tick : (tick & ~lclk);
	wire rx_drive = is_rmii ? tick : (tick & lclk);

	// transmit capture; the mac is trusted to frame data with tx_en
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_en_q <= 1'b0;
			tx_phase <= 1'b0;
			tx_lo <= 2'h0;
			line_tx_valid <= 1'b0;
			line_tx_data <= 4'h0;
		end else begin
			line_tx_valid <= 1'b0;
			if (tx_sample) begin
				tx_en_q <= tx_en;
				if (is_rmii) begin
					// two dibits, low pair first, make one nibble
					tx_phase <= tx_en & ~tx_phase;
					if (tx_en && !tx_phase) begin
						tx_lo <= txd[1:0];
					end
					if (tx_en && tx_phase) begin
						line_tx_valid <= 1'b1;
						line_tx_data <= {txd[1:0], tx_lo};
					end
				end else if (tx_en) begin
					line_tx_valid <= 1'b1;
					line_tx_data <= is_serial ? {3'h0, txd[0]} : txd;
				end
			end
		end
	end

	// receive path decode
	wire rx_bad = line_rx_valid & line_rx_symbol_err;
	wire [3:0] rx_nib = rx_bad ? CORRUPT_NIBBLE : line_rx_data;
	wire next_rx_er = ~is_serial & speed100 & rx_bad;
	// crs_dv drops to toggling once carrier is gone but data is still pending
	wire next_crs_dv = line_rx_carrier | (line_rx_valid & rx_phase);

	// receive drive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_dv <= 1'b0;
			rx_er <= 1'b0;
			rxd <= 4'h0;
			crs <= 1'b0;
			rx_phase <= 1'b0;
			rx_hi <= 2'h0;
		end else if (rx_drive) begin
			case (mode)
				MODE_MII: begin
					rx_dv <= line_rx_valid;
					rx_er <= next_rx_er;
					rxd <= rx_nib;
					crs <= line_rx_carrier;
				end
				MODE_RMII: begin
					rx_dv <= line_rx_valid;
					rx_er <= next_rx_er;
					crs <= next_crs_dv;
					rx_phase <= line_rx_valid & ~rx_phase;
					if (!rx_phase) begin
						rxd <= {2'h0, rx_nib[1:0]};
						rx_hi <= rx_nib[3:2];
					end else begin
						rxd <= {2'h0, rx_hi};
					end
				end
				MODE_SERIAL: begin
					rx_dv <= 1'b0;
					rx_er <= 1'b0;
					rxd <= {3'h0, line_rx_carrier & line_rx_data[0]};
					crs <= line_rx_carrier;
				end
				default: begin
					rx_dv <= 1'b0;
					rx_er <= 1'b0;
					rxd <= 4'h0;
					crs <= 1'b0;
				end
			endcase
		end
	end

	// end of transmission starts the heartbeat one-shot
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_en_d <= 1'b0;
		end else begin
			tx_en_d <= tx_en_q;
		end
	end

	wire tx_end = tx_en_d & ~tx_en_q;

	pmi_pulse_timer #(
		.LEN(HEARTBEAT_CYC)
	) u_hbeat (
		.clk(clk),
		.rst(rst),
		.start(tx_end),
		.active(hb_active)
	);

	// collision: rmii has no pin, so it reads low; full duplex forces low
	wire collide = tx_en_q & line_rx_carrier;
	wire hbeat_on = hb_active & hb_enable & ten_meg;
	wire next_col = ~is_rmii & ~full_duplex & (collide | hbeat_on);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			col <= 1'b0;
		end else begin
			col <= next_col;
		end
	end

	// checks
	property p_rmii_clk_idle;
		@(posedge clk) disable iff (rst) is_rmii |-> (!tx_clk && !rx_clk);
	endproperty
	a_rmii_clk_idle: assert property (p_rmii_clk_idle)
		else $error("link clocks toggled in rmii mode");

	// a speed change can leave one short link-clock pulse,
	// so a rise seen in the first cycle after the change is not judged
	property p_mii10_half;
		@(posedge clk) disable iff (rst)
			($rose(tx_clk) && is_mii && !speed100 && !$past(speed100)) |-> tx_clk[*4] ##1 !tx_clk;
	endproperty
	a_mii10_half: assert property (p_mii10_half)
		else $error("10 Mb/s mii clock high time wrong");

	property p_serial_half;
		@(posedge clk) disable iff (rst) ($rose(tx_clk) && is_serial) |=> !tx_clk;
	endproperty
	a_serial_half: assert property (p_serial_half)
		else $error("serial clock high time wrong");

	// serial half period is one cycle, so the receive clock flips every cycle
	property p_serial_rx_rate;
		@(posedge clk) disable iff (rst)
			(is_serial && !$past(rst)) |-> (rx_clk != $past(rx_clk));
	endproperty
	a_serial_rx_rate: assert property (p_serial_rx_rate)
		else $error("serial receive clock not at full rate");

	property p_rxd_on_fall;
		@(posedge clk) disable iff (rst) (is_mii && $changed(rxd)) |-> $fell(rx_clk);
	endproperty
	a_rxd_on_fall: assert property (p_rxd_on_fall)
		else $error("receive nibble changed away from falling clock");

	property p_err_corrupts;
		@(posedge clk) disable iff (rst) (!is_rmii && rx_dv && rx_er) |-> rxd == CORRUPT_NIBBLE;
	endproperty
	a_err_corrupts: assert property (p_err_corrupts)
		else $error("receive error without corrupted data");

	property p_rmii_er_in_dv;
		@(posedge clk) disable iff (rst) (is_rmii && rx_er) |-> rx_dv;
	endproperty
	a_rmii_er_in_dv: assert property (p_rmii_er_in_dv)
		else $error("rmii receive error outside data valid");

	property p_full_dup_col;
		@(posedge clk) disable iff (rst) (full_duplex && $past(full_duplex)) |-> !col;
	endproperty
	a_full_dup_col: assert property (p_full_dup_col)
		else $error("collision raised in full duplex");

	property p_heartbeat;
		@(posedge clk) disable iff (rst)
			(tx_end && !is_rmii && ten_meg && !full_duplex && hb_enable && !avs_write)
			|-> ##2 col[*8];
	endproperty
	a_heartbeat: assert property (p_heartbeat)
		else $error("no heartbeat after transmission");

	property p_mode_held;
		@(posedge clk) disable iff (rst) $past(strap_done) |-> $stable(mode);
	endproperty
	a_mode_held: assert property (p_mode_held)
		else $error("mode changed after strap capture");

	c_heartbeat: cover property (@(posedge clk) disable iff (rst) tx_end && hbeat_on);
	c_collision: cover property (@(posedge clk) disable iff (rst) collide && !full_duplex);
	c_rmii_frame: cover property (@(posedge clk) disable iff (rst) is_rmii && line_tx_valid);

endmodule

// File: verilog/pmi_pulse_timer.sv
// retriggerable one-shot: active for LEN cycles after start
module pmi_pulse_timer #(
	parameter int LEN = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// trigger
	input wire logic start,
	// level while running
	output logic active
);

	localparam int CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LOAD = CW'(LEN);

	logic [CW-1:0] remain;

	assign active = (remain != '0);

	// restarts on a new trigger, so back-to-back ends give a full pulse each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remain <= '0;
		end else if (start) begin
			remain <= LOAD;
		end else if (active) begin
			remain <= remain - 1'b1;
		end
	end

endmodule

// File: verilog/pmi_tick_div.sv
// one-cycle enable pulse every half_count cycles; a new count is taken at the next reload
module pmi_tick_div #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// divide ratio in cycles, at least one
	input wire logic [WIDTH-1:0] half_count,
	// enable pulse
	output logic tick
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	wire at_end = (count == '0);

	// reload from the live ratio so a speed change takes effect within one period
	assign next_count = at_end ? half_count - 1'b1 : count - 1'b1;
	assign tick = at_end;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule
